// ==== shared/hb_ctrl_pkg.sv ====
// Package with constants and carrier types of the half-bridge serial control block
`default_nettype none
package hb_ctrl_pkg;
  // ---------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------
  localparam int WORD_W           = 16;
  localparam int CNT_W            = 5;
  localparam int NUM_SW           = 6;
  localparam int BIT_CLEAR        = 0;
  localparam int BIT_SW_LO        = 1;
  localparam int BIT_OC_ENABLE    = 13;
  localparam int BIT_PREWARN      = 0;
  localparam int BIT_SHORT        = 13;
  localparam int BIT_OPEN         = 14;
  localparam int BIT_SUPPLY       = 15;
  localparam logic [15:0] CTRL_RESET     = 16'h2000;
  localparam logic [15:0] TEST_PATTERN_0 = 16'hF800;
  localparam logic [15:0] TEST_PATTERN_1 = 16'hE600;
  localparam logic [15:0] TEST_PATTERN_2 = 16'hE180;
  localparam logic [15:0] TEST_MASK      = 16'hFF80;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int  CLK_HZ          = 40_000_000;
  localparam int  UV_DELAY_NS     = 10_000;
  localparam int  OPEN_DELAY_NS   = 10_000;
  localparam int  UV_DELAY_CYC    = UV_DELAY_NS / 25;
  localparam int  OPEN_DELAY_CYC  = OPEN_DELAY_NS / 25;
  localparam int  FILT_W          = 16;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } serial_pins_s;

  typedef struct packed {
    logic       prewarn;
    logic       overtemp;
    logic       undervolt;
    logic [5:0] overcurrent;
    logic [5:0] undercurrent;
  } sense_s;
endpackage
`default_nettype wire

// ==== core/hb_sync2.sv ====
// Two-flop synchroniser for a bus of asynchronous levels
`default_nettype none
module hb_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,  // System clock
  input  wire logic         rst_i,  // Async reset
  input  wire logic         ce_i,   // Clock enable
  input  wire logic [W-1:0] d_i,    // Async input
  output var  logic [W-1:0] q_o     // Synchronised
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } st_s;
  st_s st_reg;
  st_s st_next;

  always_comb begin
    st_next = st_reg;
    if (ce_i) begin
      st_next.s1 = d_i;
      st_next.s2 = st_reg.s1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;
endmodule
`default_nettype wire

// ==== core/hb_delay_filter.sv ====
// Persistence filter: output rises after input held high for DELAY+1 cycles
`default_nettype none
module hb_delay_filter #(
  parameter int DELAY = 400,
  parameter int CW    = 16
) (
  input  wire logic clk_i,  // System clock
  input  wire logic rst_i,  // Async reset
  input  wire logic ce_i,   // Clock enable
  input  wire logic d_i,    // Synchronised condition
  output var  logic q_o     // Condition held long enough
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          hit;
  } st_s;
  st_s st_reg;
  st_s st_next;

  always_comb begin
    st_next = st_reg;
    if (ce_i) begin
      if (!d_i) begin
        st_next.cnt = '0;
        st_next.hit = 1'b0;
      end else if (st_reg.cnt >= CW'(DELAY)) begin
        st_next.hit = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.hit;
endmodule
`default_nettype wire

// ==== core/halfbridge_serial_control.sv ====
// Serial control and status logic of a triple half-bridge driver
//
// Contract
// - Transfer starts on chip select falling.
// - Serial input sampled on serial clock falling.
// - Control word applied only at chip select rise.
// - Serial output tristate while chip select high.
// - Serial output changes on serial clock rise.
// - Status shifted LSB first, prewarning first.
// - Status clear bit clears sticky fault flags.
// - Bits one to six turn switches on.
// - Bit thirteen enables overcurrent shutdown.
// - Status bit zero is thermal prewarning.
// - Status bits one-six show switch states.
// - Status bit thirteen flags short trip.
// - Status bit fourteen flags open load.
// - Status bit fifteen flags supply undervoltage.
// - Reset control word has only bit thirteen.
// - Persistent undervoltage sets flag, disables outputs.
// - Outputs return at once on supply recovery.
// - Supply flag stays until status clear.
// - Persistent low on-current sets open-load flag.
// - Inhibit low turns off, clears, resets.
// - Overtemperature disables outputs until cool and clear.
// - Short flag set regardless; clear re-enables tripped.
`default_nettype none
module halfbridge_serial_control
  import hb_ctrl_pkg::*;
#(
  parameter int UV_DELAY   = UV_DELAY_CYC,
  parameter int OPEN_DELAY = OPEN_DELAY_CYC
) (
  input  wire logic              SYS_CLK_I,        // 40 MHz system clock
  input  wire logic              RST_I,            // Async power-on reset, high
  input  wire logic              CE_I,             // Clock enable
  input  wire logic              CS_N_I,           // Chip select, active low
  input  wire logic              SCLK_I,           // Serial clock pin
  input  wire logic              SERIAL_IN_I,      // Serial data in
  input  wire logic              STANDBY_INHIBIT_N_I, // Low = standby
  input  wire logic              PREWARN_I,        // Thermal prewarning sense
  input  wire logic              OVERTEMP_I,       // Thermal shutdown sense
  input  wire logic              UNDERVOLT_I,      // Power stage supply low
  input  wire logic [NUM_SW-1:0] OVERCURRENT_I,    // Per-switch overcurrent
  input  wire logic [NUM_SW-1:0] UNDERCURRENT_I,   // Per-switch current below open-load
  output var  logic              SERIAL_OUT_O,     // Serial data out
  output var  logic              SERIAL_OUT_OE_O,  // Serial out enable
  output var  logic [NUM_SW-1:0] SWITCH_ON_O,      // Switch gate enables
  output var  logic              BRIDGE_HIZ_O,     // All switches high impedance
  output var  logic              TEST_MODE_O       // Test pattern executed
);
  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  localparam int NSYNC = 3 + 1 + 3 + 2 * NUM_SW;
  logic [NSYNC-1:0] raw_w;
  logic [NSYNC-1:0] syn_w;
  serial_pins_s     pins_w;
  sense_s           sense_w;
  logic             inh_n_w;
  logic             uv_long_w;
  logic             open_long_w;

  // Select enters inverted so a cleared synchroniser reads deselected, no false fall after reset
  assign raw_w = {~CS_N_I, SCLK_I, SERIAL_IN_I, STANDBY_INHIBIT_N_I, PREWARN_I, OVERTEMP_I,
                  UNDERVOLT_I, OVERCURRENT_I, UNDERCURRENT_I};

  hb_sync2 #(.W(NSYNC)) u_sync (
    .clk_i (SYS_CLK_I),
    .rst_i (RST_I),
    .ce_i  (CE_I),
    .d_i   (raw_w),
    .q_o   (syn_w)
  );

  assign pins_w  = syn_w[NSYNC-1 -: 3] ^ 3'h4;
  assign inh_n_w = syn_w[NSYNC-4];
  assign sense_w = syn_w[NSYNC-5:0];

  // ---------------------------------------------------------------
  // Fault persistence
  // ---------------------------------------------------------------
  hb_delay_filter #(.DELAY(UV_DELAY), .CW(FILT_W)) u_uv_filt (
    .clk_i (SYS_CLK_I),
    .rst_i (RST_I),
    .ce_i  (CE_I),
    .d_i   (sense_w.undervolt),
    .q_o   (uv_long_w)
  );

  hb_delay_filter #(.DELAY(OPEN_DELAY), .CW(FILT_W)) u_open_filt (
    .clk_i (SYS_CLK_I),
    .rst_i (RST_I),
    .ce_i  (CE_I),
    .d_i   (|(sense_w.undercurrent & SWITCH_ON_O)),
    .q_o   (open_long_w)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {IDLE, SHIFT} link_e;

  typedef struct packed {
    link_e             link;
    logic              cs_d;
    logic              sclk_d;
    logic [WORD_W-1:0] shift_in;
    logic [WORD_W-1:0] shift_out;
    logic [CNT_W-1:0]  nbits;
    logic [WORD_W-1:0] ctrl;
    logic [NUM_SW-1:0] tripped;
    logic              ot_latched;
    logic              short_flag;
    logic              open_load_flag;
    logic              supply_fail_flag;
    logic              sdo;
    logic              sdo_oe;
    logic [NUM_SW-1:0] sw_on;
    logic              hiz;
    logic              test;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic              cs_fall_w;
  logic              cs_rise_w;
  logic              sclk_rise_w;
  logic              sclk_fall_w;
  logic [WORD_W-1:0] status_w;
  logic [WORD_W-1:0] word_w;
  logic              clear_w;
  logic [NUM_SW-1:0] trip_w;

  assign cs_fall_w   = st_reg.cs_d && !pins_w.cs_n;
  assign cs_rise_w   = !st_reg.cs_d && pins_w.cs_n;
  assign sclk_rise_w = !st_reg.sclk_d && pins_w.sclk;
  assign sclk_fall_w = st_reg.sclk_d && !pins_w.sclk;

  // Status word snapshot
  always_comb begin
    status_w                     = '0;
    status_w[BIT_PREWARN]        = sense_w.prewarn;
    status_w[BIT_SW_LO +: NUM_SW] = st_reg.sw_on;
    status_w[BIT_SHORT]          = st_reg.short_flag;
    status_w[BIT_OPEN]           = st_reg.open_load_flag;
    status_w[BIT_SUPPLY]         = st_reg.supply_fail_flag;
  end

  // Word as it stands after the last sample, bits fill from the top
  assign word_w  = st_reg.shift_in;
  assign clear_w = cs_rise_w && (st_reg.link == SHIFT) && word_w[BIT_CLEAR];
  assign trip_w  = sense_w.overcurrent & st_reg.sw_on;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (CE_I) begin
      st_next.cs_d   = pins_w.cs_n;
      st_next.sclk_d = pins_w.sclk;

      unique case (st_reg.link)
        IDLE: begin
          if (cs_fall_w) begin
            st_next.link      = SHIFT;
            st_next.nbits     = '0;
            st_next.shift_out = status_w;
            st_next.sdo       = status_w[0];
            st_next.sdo_oe    = 1'b1;
          end
        end
        SHIFT: begin
          if (cs_rise_w) begin
            st_next.link   = IDLE;
            st_next.sdo_oe = 1'b0;
            if (st_reg.nbits == CNT_W'(WORD_W)) begin
              st_next.ctrl = word_w;
              st_next.test = ((word_w & TEST_MASK) == TEST_PATTERN_0) ||
                             ((word_w & TEST_MASK) == TEST_PATTERN_1) ||
                             ((word_w & TEST_MASK) == TEST_PATTERN_2);
            end
          end else begin
            if (sclk_fall_w) begin
              st_next.shift_in = {pins_w.sdi, st_reg.shift_in[WORD_W-1:1]};
              if (st_reg.nbits != CNT_W'(WORD_W)) begin
                st_next.nbits = st_reg.nbits + 1'b1;
              end
            end
            if (sclk_rise_w && st_reg.nbits != '0) begin
              st_next.shift_out = {1'b0, st_reg.shift_out[WORD_W-1:1]};
              st_next.sdo       = st_reg.shift_out[1];
            end
          end
        end
      endcase

      // Sticky flags: set beats clear
      if (clear_w && st_reg.nbits == CNT_W'(WORD_W)) begin
        st_next.short_flag       = 1'b0;
        st_next.open_load_flag   = 1'b0;
        st_next.supply_fail_flag = 1'b0;
        st_next.tripped          = '0;
        if (!sense_w.overtemp) begin
          st_next.ot_latched = 1'b0;
        end
      end
      if (|trip_w) begin
        st_next.short_flag = 1'b1;
        if (st_reg.ctrl[BIT_OC_ENABLE]) begin
          st_next.tripped = st_next.tripped | trip_w;
        end
      end
      if (open_long_w) begin
        st_next.open_load_flag = 1'b1;
      end
      if (uv_long_w) begin
        st_next.supply_fail_flag = 1'b1;
      end
      if (sense_w.overtemp) begin
        st_next.ot_latched = 1'b1;
      end

      // Switch drive
      if (uv_long_w || st_next.ot_latched) begin
        st_next.sw_on = '0;
      end else begin
        st_next.sw_on = st_next.ctrl[BIT_SW_LO +: NUM_SW] & ~st_next.tripped;
      end
      st_next.hiz = 1'b0;

      // Standby overrides everything and holds the block in reset state, but with hiz set
      if (!inh_n_w) begin
        st_next                  = '0;
        st_next.link             = IDLE;
        st_next.cs_d             = 1'b1;
        st_next.ctrl             = CTRL_RESET;
        st_next.hiz              = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_reg      <= '0;
      st_reg.link <= IDLE;
      st_reg.cs_d <= 1'b1;
      st_reg.ctrl <= CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign SERIAL_OUT_O    = st_reg.sdo;
  assign SERIAL_OUT_OE_O = st_reg.sdo_oe;
  assign SWITCH_ON_O     = st_reg.sw_on;
  assign BRIDGE_HIZ_O    = st_reg.hiz;
  assign TEST_MODE_O     = st_reg.test;
endmodule
`default_nettype wire

// ==== testbench/hb_ctrl_sva.sv ====
// Port-level properties of the half-bridge serial control block
`default_nettype none
module hb_ctrl_sva
  import hb_ctrl_pkg::*;
#(
  parameter int UV_DELAY   = UV_DELAY_CYC,
  parameter int OPEN_DELAY = OPEN_DELAY_CYC
) (
  input wire logic              SYS_CLK_I,           // Clock
  input wire logic              RST_I,               // Reset
  input wire logic              CE_I,                // Enable
  input wire logic              CS_N_I,              // Select
  input wire logic              SCLK_I,              // Link clock
  input wire logic              SERIAL_IN_I,         // Data in
  input wire logic              STANDBY_INHIBIT_N_I, // Standby
  input wire logic              PREWARN_I,           // Prewarn
  input wire logic              OVERTEMP_I,          // Overtemp
  input wire logic              UNDERVOLT_I,         // Undervolt
  input wire logic [NUM_SW-1:0] OVERCURRENT_I,       // Overcurrent
  input wire logic [NUM_SW-1:0] UNDERCURRENT_I,      // Undercurrent
  input wire logic              SERIAL_OUT_O,        // Data out
  input wire logic              SERIAL_OUT_OE_O,     // Out enable
  input wire logic [NUM_SW-1:0] SWITCH_ON_O,         // Switches
  input wire logic              BRIDGE_HIZ_O,        // High impedance
  input wire logic              TEST_MODE_O          // Test mode
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Cycle ages of pin events
  // ---------------------------------------------------------------
  logic [11:0] sclk_age_reg;
  logic [11:0] cs_age_reg;
  logic [11:0] ev_age_reg;
  logic [11:0] uv_cnt_reg;
  function automatic logic [11:0] inc(input logic [11:0] v);
    return (v == 12'hFFF) ? v : v + 12'h001;
  endfunction
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sclk_age_reg <= 12'hFFF;
      cs_age_reg   <= 12'hFFF;
      ev_age_reg   <= 12'hFFF;
      uv_cnt_reg   <= 12'h000;
    end else begin
      sclk_age_reg <= $rose(SCLK_I) ? 12'h000 : inc(sclk_age_reg);
      cs_age_reg   <= $rose(CS_N_I) ? 12'h000 : inc(cs_age_reg);
      ev_age_reg   <= $changed({UNDERVOLT_I, OVERTEMP_I, OVERCURRENT_I, STANDBY_INHIBIT_N_I}) ?
                      12'h000 : inc(ev_age_reg);
      uv_cnt_reg   <= UNDERVOLT_I ? inc(uv_cnt_reg) : 12'h000;
    end
  end
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);
  property p_oe_idle; CS_N_I [*5] |-> !SERIAL_OUT_OE_O; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("serial out driven while deselected");
  property p_oe_on; $fell(CS_N_I) && STANDBY_INHIBIT_N_I ##1 !CS_N_I [*5] |-> SERIAL_OUT_OE_O; endproperty
  a_oe_on: assert property (p_oe_on) else $error("serial out not driven after select");
  property p_out_rise; $changed(SERIAL_OUT_O) && SERIAL_OUT_OE_O && $past(SERIAL_OUT_OE_O, 3) |-> sclk_age_reg <= 5;
  endproperty
  a_out_rise: assert property (p_out_rise) else $error("serial out moved away from clock rise");
  property p_sw_cause; $changed(SWITCH_ON_O) |-> cs_age_reg <= 6 || ev_age_reg <= UV_DELAY + 10; endproperty
  a_sw_cause: assert property (p_sw_cause) else $error("switches moved without a cause");
  property p_standby; !STANDBY_INHIBIT_N_I [*6] |-> SWITCH_ON_O == 6'h00 && BRIDGE_HIZ_O; endproperty
  a_standby: assert property (p_standby) else $error("standby did not disable bridge");
  property p_awake; STANDBY_INHIBIT_N_I [*6] |-> !BRIDGE_HIZ_O; endproperty
  a_awake: assert property (p_awake) else $error("bridge floating while awake");
  property p_uv_off; uv_cnt_reg >= UV_DELAY + 8 |-> SWITCH_ON_O == 6'h00; endproperty
  a_uv_off: assert property (p_uv_off) else $error("switches on during undervoltage");
  property p_ot_off; OVERTEMP_I [*8] |-> SWITCH_ON_O == 6'h00; endproperty
  a_ot_off: assert property (p_ot_off) else $error("switches on during overtemperature");
  c_frame: cover property ($rose(SERIAL_OUT_OE_O));
  c_trip: cover property ($fell(SWITCH_ON_O[1]));
  c_hiz: cover property ($rose(BRIDGE_HIZ_O));
endmodule
bind halfbridge_serial_control hb_ctrl_sva #(.UV_DELAY(UV_DELAY), .OPEN_DELAY(OPEN_DELAY)) hb_ctrl_sva_i (
  .SYS_CLK_I, .RST_I, .CE_I, .CS_N_I, .SCLK_I, .SERIAL_IN_I, .STANDBY_INHIBIT_N_I, .PREWARN_I,
  .OVERTEMP_I, .UNDERVOLT_I, .OVERCURRENT_I, .UNDERCURRENT_I, .SERIAL_OUT_O, .SERIAL_OUT_OE_O,
  .SWITCH_ON_O, .BRIDGE_HIZ_O, .TEST_MODE_O);
`default_nettype wire

// ==== testbench/hb_host_model.sv ====
// Behavioural host that runs serial frames on the control pins
`default_nettype none
module hb_host_model
  import hb_ctrl_pkg::*;
(
  input  wire logic     clk_i,    // System clock
  input  wire logic     sdo_i,    // Data from block
  input  wire logic     sdo_oe_i, // Data enable
  output var  serial_pins_s pins_o // Select, clock, data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Frame driver, half link period is four system clocks
  // ---------------------------------------------------------------
  initial pins_o = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] st);
    st = 16'h0000;
    pins_o.cs_n = 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      pins_o.sdi = w[i];
      pins_o.sclk = 1'b1;
      half();
      st[i] = sdo_oe_i ? sdo_i : 1'bz;
      pins_o.sclk = 1'b0;
      half();
    end
    pins_o.cs_n = 1'b1;
    pins_o.sdi = 1'b0;
    repeat (8) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== testbench/test_halfbridge_serial_control.sv ====
// Self-checking bench of the half-bridge serial control block
`default_nettype none
module test_halfbridge_serial_control import hb_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [15:0] w; logic pw;} row_s;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         inh_n = 1'b1;
  logic         prewarn = 1'b0;
  logic         overtemp = 1'b0;
  logic         undervolt = 1'b0;
  logic [5:0]   oc = 6'h00;
  logic [5:0]   uc = 6'h00;
  logic         sdo;
  logic         sdo_oe;
  logic         hiz;
  logic         tmode;
  logic [5:0]   sw;
  logic [5:0]   prev;
  logic [15:0]  st;
  serial_pins_s pins;
  int           bad_count = 0;
  int           n_tests = 0;
  int           cyc = 0;
  row_s         rows [5] = '{'{16'h2002, 1'b0}, '{16'h1F84, 1'b1}, '{16'h407E, 1'b0},
                             '{16'h8000, 1'b1}, '{16'h2054, 1'b0}};
  halfbridge_serial_control #(.UV_DELAY(4), .OPEN_DELAY(4)) halfbridge_serial_control_i (
    .SYS_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .CS_N_I(pins.cs_n), .SCLK_I(pins.sclk),
    .SERIAL_IN_I(pins.sdi), .STANDBY_INHIBIT_N_I(inh_n), .PREWARN_I(prewarn), .OVERTEMP_I(overtemp),
    .UNDERVOLT_I(undervolt), .OVERCURRENT_I(oc), .UNDERCURRENT_I(uc), .SERIAL_OUT_O(sdo),
    .SERIAL_OUT_OE_O(sdo_oe), .SWITCH_ON_O(sw), .BRIDGE_HIZ_O(hiz), .TEST_MODE_O(tmode));
  hb_host_model hb_host_model_i (.clk_i(clk), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .pins_o(pins));
  // ---------------------------------------------------------------
  // Clock, watchdog and checking tasks
  // ---------------------------------------------------------------
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic xf(input logic [15:0] w, input logic [15:0] exp);
    hb_host_model_i.xfer(w, 16, st);
    chk("status", exp, st);
  endtask
  task automatic swc(input logic [5:0] e);
    chk("switches", {10'h000, e}, {10'h000, sw});
  endtask
  initial begin
    idle(5);
    rst = 1'b0;
    idle(4);
    chk("reset", 16'h0000, {7'h00, sdo_oe, tmode, hiz, sw});
    prev = 6'h00;
    foreach (rows[k]) begin
      prewarn = rows[k].pw;
      idle(4);
      xf(rows[k].w, {9'h000, prev, rows[k].pw});
      prev = rows[k].w[6:1];
      swc(prev);
    end
    prewarn = 1'b0;
    hb_host_model_i.xfer(16'h007E, 8, st);
    chk("short frame", 16'h0054, st);
    swc(6'h2A);
    oc = 6'h02;
    idle(10);
    swc(6'h28);
    oc = 6'h00;
    xf(16'h0054, 16'h2050);
    oc = 6'h08;
    idle(10);
    swc(6'h28);
    oc = 6'h00;
    xf(16'h0055, 16'h2050);
    swc(6'h2A);
    xf(16'h0054, 16'h0054);
    undervolt = 1'b1;
    idle(16);
    swc(6'h00);
    undervolt = 1'b0;
    idle(5);
    swc(6'h2A);
    uc = 6'h02;
    idle(16);
    uc = 6'h00;
    xf(16'h0054, 16'hC054);
    xf(16'h0055, 16'hC054);
    xf(16'h0054, 16'h0054);
    overtemp = 1'b1;
    idle(10);
    swc(6'h00);
    overtemp = 1'b0;
    idle(10);
    swc(6'h00);
    xf(16'h0055, 16'h0000);
    swc(6'h2A);
    inh_n = 1'b0;
    idle(6);
    chk("standby", 16'h0040, {9'h000, hiz, sw});
    inh_n = 1'b1;
    idle(6);
    chk("wake", 16'h0000, {9'h000, hiz, sw});
    xf(16'h0000, 16'h0000);
    xf(16'hE600, 16'h0000);
    chk("test mode", 16'h0001, {15'h0000, tmode});
    swc(6'h00);
    stop_test();
  end
endmodule
`default_nettype wire
